// ---- include/ssse_map.vh ----
// ssse_map.vh: opcode codes, flag bit positions and reset values for the execution block
// assumes inclusion by bare name from rtl files
`ifndef SSSE_MAP_VH
`define SSSE_MAP_VH
`define SSSE_OP_NOP 3'h0
`define SSSE_OP_SUB_IMM 3'h1
`define SSSE_OP_SUB_MEM 3'h2
`define SSSE_OP_SUB_TO_MEM 3'h3
`define SSSE_OP_DEC_SKIP 3'h4
`define SSSE_OP_DEC_SKIP_WORK 3'h5
`define SSSE_OP_SET 3'h6
`define SSSE_FLG_CARRY 0
`define SSSE_FLG_HALF 1
`define SSSE_FLG_ZERO 2
`define SSSE_FLG_RANGE 3
`define SSSE_FLG_SEC 4
`define SSSE_FLG_CZERO 5
`define SSSE_FLAGS_RST 6'h00
`define SSSE_WORK_RST 8'h00
`define SSSE_ALL_ONES 8'hff
`endif

// ---- rtl/ssse_sub_alu.v ----
// ssse_sub_alu.v: combinational subtract-with-borrow unit; the decrement is done in the execution block
// assumes operands are stable for the cycle in which the result is used
`include "ssse_map.vh"
module ssse_sub_alu #(
   parameter W = 8
) (
   // operands
   input wire [W-1:0] minuend_i,
   input wire [W-1:0] subtrahend_i,
   input wire carry_i,
   // results
   output wire [W-1:0] diff_o,
   output wire carry_o,
   output wire half_carry_o,
   output wire overflow_o,
   output wire zero_o
);
   wire [W:0] full;
   wire [4:0] low;
   // carry is an inverted borrow: subtract the complement of carry in
   assign full = {1'b0, minuend_i} - {1'b0, subtrahend_i} - {{W{1'b0}}, ~carry_i};
   assign low = {1'b0, minuend_i[3:0]} - {1'b0, subtrahend_i[3:0]} - {4'h0, ~carry_i};
   assign diff_o = full[W-1:0];
   assign carry_o = ~full[W];
   assign half_carry_o = ~low[4];
   assign overflow_o = (minuend_i[W-1] ^ subtrahend_i[W-1]) & (minuend_i[W-1] ^ full[W-1]);
   assign zero_o = (full[W-1:0] == {W{1'b0}});
endmodule

// ---- rtl/ssse_exec.v ----
// ssse_exec.v: executes subtract-with-borrow, decrement-and-skip and set-memory instructions
// assumes the decoder presents one instruction with valid for one cycle, memory read data
// for the addressed byte is already on mem_rdata_i, and the write is done by mem_we_o
`include "ssse_map.vh"
// Operation
// - immediate subtract-with-borrow: working minus immediate minus not-carry into working.
// - after subtract, carry cleared if difference negative, set if zero or positive.
// - subtract variants update range, zero, half, carry, secondary and carry-zero flags.
// - memory-destination subtract stores difference into memory, working register unchanged.
// - decrement-skip writes byte minus one to memory; skip when zero; flags kept.
// - a skip inserts one dummy cycle, giving two machine cycles in total.
// - nonzero decrement result continues with the following instruction, no skip.
// - decrement-skip to working puts byte minus one in working, memory kept.
// - set-memory writes all ones into the addressed memory byte.
module ssse_exec #(
   parameter W = 8
) (
   // clock and reset
   input wire core_clk_i,
   input wire rst_n_i,
   // instruction from decoder
   input wire instr_valid_i,
   input wire [2:0] opcode_i,
   input wire [W-1:0] imm_i,
   // data memory
   input wire [W-1:0] mem_rdata_i,
   output reg mem_we_o,
   output reg [W-1:0] mem_wdata_o,
   // core state
   output reg [W-1:0] working_register_o,
   output reg range_exceeded_flag_o,
   output reg zero_flag_o,
   output reg half_carry_flag_o,
   output reg carry_flag_o,
   output reg secondary_carry_flag_o,
   output reg carry_zero_flag_o,
   // pipeline control
   output reg skip_o,
   output reg busy_o
);
   // skip sequencer: one dummy cycle follows a taken skip
   localparam SSSE_ST_RUN = 1'b0;
   localparam SSSE_ST_DUMMY = 1'b1;

   // sequencer state and next values
   reg state_q;
   reg state_d;
   reg [W-1:0] sub_b;
   reg [W-1:0] work_d;
   reg [W-1:0] wdata_d;
   reg [5:0] flags_d;
   reg we_d;
   reg skip_d;

   // arithmetic results
   wire [5:0] flags_q;
   wire [W-1:0] diff;
   wire c_out;
   wire half_out;
   wire range_out;
   wire z_out;
   wire [W-1:0] dec_val;
   wire dec_zero;
   wire exec_ok;

   // subtract-with-borrow family, all three forms
   function ssse_is_sub;
      input [2:0] op;
      begin
         case (op)
            `SSSE_OP_SUB_IMM: ssse_is_sub = 1'b1;
            `SSSE_OP_SUB_MEM: ssse_is_sub = 1'b1;
            `SSSE_OP_SUB_TO_MEM: ssse_is_sub = 1'b1;
            default: ssse_is_sub = 1'b0;
         endcase
      end
   endfunction

   // decrement-and-skip family, both destinations
   function ssse_is_dec;
      input [2:0] op;
      begin
         case (op)
            `SSSE_OP_DEC_SKIP: ssse_is_dec = 1'b1;
            `SSSE_OP_DEC_SKIP_WORK: ssse_is_dec = 1'b1;
            default: ssse_is_dec = 1'b0;
         endcase
      end
   endfunction

   // operations whose result goes back to the addressed byte
   function ssse_writes_mem;
      input [2:0] op;
      begin
         case (op)
            `SSSE_OP_SUB_TO_MEM: ssse_writes_mem = 1'b1;
            `SSSE_OP_DEC_SKIP: ssse_writes_mem = 1'b1;
            `SSSE_OP_SET: ssse_writes_mem = 1'b1;
            default: ssse_writes_mem = 1'b0;
         endcase
      end
   endfunction

   // only the immediate form takes its subtrahend from the instruction
   function ssse_uses_imm;
      input [2:0] op;
      begin
         case (op)
            `SSSE_OP_SUB_IMM: ssse_uses_imm = 1'b1;
            default: ssse_uses_imm = 1'b0;
         endcase
      end
   endfunction

   function ssse_is_zero;
      input [W-1:0] v;
      begin
         ssse_is_zero = (v == {W{1'b0}});
      end
   endfunction

   ssse_sub_alu #(.W(W)) u_alu (
      .minuend_i(working_register_o),
      .subtrahend_i(sub_b),
      .carry_i(carry_flag_o),
      .diff_o(diff),
      .carry_o(c_out),
      .half_carry_o(half_out),
      .overflow_o(range_out),
      .zero_o(z_out)
   );

   assign flags_q = {carry_zero_flag_o, secondary_carry_flag_o, range_exceeded_flag_o,
      zero_flag_o, half_carry_flag_o, carry_flag_o};
   assign dec_val = mem_rdata_i - {{(W-1){1'b0}}, 1'b1};
   assign dec_zero = ssse_is_zero(dec_val);
   // the instruction arriving during the dummy cycle is discarded
   assign exec_ok = instr_valid_i & (state_q == SSSE_ST_RUN);

   always @* begin
      sub_b = mem_rdata_i;
      if (ssse_uses_imm(opcode_i)) begin
         sub_b = imm_i;
      end
   end

   // next values; working, write data and flags keep their value unless named below, write enable and skip default to zero
   always @* begin
      work_d = working_register_o;
      wdata_d = mem_wdata_o;
      flags_d = flags_q;
      we_d = 1'b0;
      skip_d = 1'b0;
      if (exec_ok) begin
         we_d = ssse_writes_mem(opcode_i);
         if (ssse_is_sub(opcode_i)) begin
            flags_d[`SSSE_FLG_RANGE] = range_out;
            flags_d[`SSSE_FLG_ZERO] = z_out;
            flags_d[`SSSE_FLG_HALF] = half_out;
            flags_d[`SSSE_FLG_CARRY] = c_out;
            flags_d[`SSSE_FLG_SEC] = ~range_out ^ c_out;
            // carry-zero is set only if this step and the previous zero flag were both zero
            flags_d[`SSSE_FLG_CZERO] = z_out & zero_flag_o;
         end
         if (ssse_is_dec(opcode_i)) begin
            skip_d = dec_zero;
         end
         case (opcode_i)
            `SSSE_OP_SUB_IMM, `SSSE_OP_SUB_MEM: begin
               work_d = diff;
            end
            `SSSE_OP_SUB_TO_MEM: begin
               wdata_d = diff;
            end
            `SSSE_OP_DEC_SKIP: begin
               wdata_d = dec_val;
            end
            `SSSE_OP_DEC_SKIP_WORK: begin
               work_d = dec_val;
            end
            `SSSE_OP_SET: begin
               wdata_d = `SSSE_ALL_ONES;
            end
            default: work_d = working_register_o;
         endcase
      end
   end

   // sequencer: run, or the dummy cycle after a taken skip
   always @* begin
      case (state_q)
         SSSE_ST_RUN: begin
            state_d = skip_d ? SSSE_ST_DUMMY : SSSE_ST_RUN;
         end
         SSSE_ST_DUMMY: state_d = SSSE_ST_RUN;
         default: state_d = SSSE_ST_RUN;
      endcase
   end

   // every output is taken straight from a flip-flop
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         state_q <= SSSE_ST_RUN;
         working_register_o <= `SSSE_WORK_RST;
         {carry_zero_flag_o, secondary_carry_flag_o, range_exceeded_flag_o,
            zero_flag_o, half_carry_flag_o, carry_flag_o} <= `SSSE_FLAGS_RST;
         mem_we_o <= 1'b0;
         mem_wdata_o <= {W{1'b0}};
         skip_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         state_q <= state_d;
         working_register_o <= work_d;
         {carry_zero_flag_o, secondary_carry_flag_o, range_exceeded_flag_o,
            zero_flag_o, half_carry_flag_o, carry_flag_o} <= flags_d;
         mem_we_o <= we_d;
         mem_wdata_o <= wdata_d;
         skip_o <= skip_d;
         // the dummy cycle is marked for exactly as long as the skip pulse
         busy_o <= skip_d;
      end
   end
endmodule

// ---- bench/ssse_exec_chk.sv ----
// ssse_exec_chk.sv: port assertions for the execution block
// assumes binding into ssse_exec with W of 8
module ssse_exec_chk (
   // inputs
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic instr_valid_i,
   input wire logic [2:0] opcode_i,
   input wire logic [7:0] mem_rdata_i,
   // outputs
   input wire logic mem_we_o,
   input wire logic [7:0] mem_wdata_o,
   input wire logic [7:0] working_register_o,
   input wire logic carry_flag_o,
   input wire logic skip_o,
   input wire logic busy_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic t = instr_valid_i & ~skip_o;
   a_dec_zero: assert property (t && opcode_i == 3'h4 && mem_rdata_i == 8'h01
      |=> skip_o && busy_o && mem_we_o && mem_wdata_o == 8'h00) else $error("no skip");
   a_dec_nonzero: assert property (t && opcode_i[2:1] == 2'b10
      && mem_rdata_i != 8'h01 |=> !skip_o) else $error("bad skip");
   a_set_ones: assert property (t && opcode_i == 3'h6
      |=> mem_we_o && mem_wdata_o == 8'hff) else $error("set failed");
   a_dec_working: assert property (t && opcode_i == 3'h5
      |=> working_register_o == $past(mem_rdata_i) - 8'h01 && !mem_we_o)
      else $error("dec to working failed");
   a_skip_single: assert property (skip_o |=> !skip_o && !busy_o)
      else $error("long skip");
   a_skipped_inert: assert property (skip_o |=> !mem_we_o
      && $stable(working_register_o) && $stable(carry_flag_o)) else $error("not inert");
   a_sub_mem_keep: assert property (t && opcode_i == 3'h3
      |=> mem_we_o && $stable(working_register_o)) else $error("sub to mem failed");
   a_dec_flags: assert property (t && opcode_i[2:1] == 2'b10
      |=> $stable(carry_flag_o)) else $error("flag moved");
endmodule

// ---- bench/tb_top.sv ----
// tb_top.sv: random instruction stream checked against a bench model
// assumes ssse_exec with W of 8 and the checker bound at the foot
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 0, rst_n_i = 0, instr_valid_i = 0, mem_we_o, skip_o, busy_o;
   logic range_exceeded_flag_o, zero_flag_o, half_carry_flag_o, carry_flag_o;
   logic secondary_carry_flag_o, carry_zero_flag_o, c = 0, z = 0, we = 0, sk = 0, nv;
   logic ov = 0, ac = 0, sc = 0, cz = 0;
   logic [4:0] lo;
   logic [2:0] opcode_i = 3'h0, no;
   logic [7:0] imm_i = 8'h00, mem_rdata_i = 8'h00, mem_wdata_o, working_register_o;
   logic [7:0] w = 8'h00, wd = 8'h00, nm, ni;
   logic [8:0] r;
   int n_fail = 0, n_compared = 0, seed = 32'hf68f, i;
   ssse_exec u_dut (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
      .opcode_i(opcode_i), .imm_i(imm_i), .mem_rdata_i(mem_rdata_i), .mem_we_o(mem_we_o),
      .mem_wdata_o(mem_wdata_o), .working_register_o(working_register_o),
      .range_exceeded_flag_o(range_exceeded_flag_o), .zero_flag_o(zero_flag_o),
      .half_carry_flag_o(half_carry_flag_o), .carry_flag_o(carry_flag_o),
      .secondary_carry_flag_o(secondary_carry_flag_o),
      .carry_zero_flag_o(carry_zero_flag_o), .skip_o(skip_o), .busy_o(busy_o)
   );
   always #10 core_clk_i = ~core_clk_i;
   task chk(input string n, input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task test_done;
      if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task put(input logic [7:0] v);
      wd = v;
      we = 1;
   endtask
   // carry in the model is an inverted borrow
   task sub_borrow(input logic [7:0] m, input logic tm);
      r = {1'b0, w} - m - !c;
      lo = {1'b0, w[3:0]} - m[3:0] - !c;
      ov = (w[7] ^ m[7]) & (w[7] ^ r[7]);
      ac = !lo[4];
      c = !r[8];
      sc = !ov ^ c;
      cz = (r[7:0] == 8'h00) & z;
      z = r[7:0] == 8'h00;
      if (tm) put(r[7:0]);
      else w = r[7:0];
   endtask
   initial begin
      repeat (3) @(posedge core_clk_i);
      rst_n_i <= 1;
      for (i = 0; i < 800; i++) begin
         nv = ($random(seed) & 3) != 0;
         no = 3'({$random(seed)} % 7);
         ni = 8'($random(seed));
         nm = (i % 4 == 0) ? 8'h01 : 8'($random(seed));
         @(posedge core_clk_i);
         instr_valid_i <= nv;
         opcode_i <= no;
         imm_i <= ni;
         mem_rdata_i <= nm;
         #1;
         chk("work", working_register_o, w);
         chk("wdata", mem_wdata_o, wd);
         chk("we", mem_we_o, we);
         chk("skip", skip_o, sk);
         chk("carry", carry_flag_o, c);
         chk("zero", zero_flag_o, z);
         chk("range", range_exceeded_flag_o, ov);
         chk("half", half_carry_flag_o, ac);
         chk("second", secondary_carry_flag_o, sc);
         chk("czero", carry_zero_flag_o, cz);
         chk("busy", busy_o, sk);
         we = 0;
         if (nv && !sk)
            case (no)
               3'h1: sub_borrow(ni, 0);
               3'h2: sub_borrow(nm, 0);
               3'h3: sub_borrow(nm, 1);
               3'h4: put(nm - 8'h01);
               3'h5: w = nm - 8'h01;
               3'h6: put(8'hff);
            endcase
         sk = nv && !sk && (no == 3'h4 && wd == 8'h00 || no == 3'h5 && w == 8'h00);
      end
      test_done;
   end
endmodule
bind ssse_exec ssse_exec_chk u_chk (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
   .opcode_i(opcode_i), .mem_rdata_i(mem_rdata_i), .mem_we_o(mem_we_o),
   .mem_wdata_o(mem_wdata_o), .working_register_o(working_register_o),
   .carry_flag_o(carry_flag_o), .skip_o(skip_o), .busy_o(busy_o)
);
